/* mcrsu_regs.svh */
// register offsets, field positions and reset values of the register stack unit
`ifndef MCRSU_REGS_SVH
`define MCRSU_REGS_SVH
`define MCRSU_OFS_ACC 8'h00
`define MCRSU_OFS_IDX 8'h04
`define MCRSU_OFS_IP 8'h08
`define MCRSU_OFS_STK 8'h0c
`define MCRSU_OFS_FLAGS 8'h10
`define MCRSU_OFS_STATUS 8'h14
`define MCRSU_OFS_CTRL 8'h18
`define MCRSU_CTRL_RELOAD 0
`define MCRSU_ST_BUSY 0
`define MCRSU_ST_EXT 1
`define MCRSU_ST_TMR 2
`define MCRSU_STK_FIXED 7'h03
`define MCRSU_STK_RELOAD 5'h1f
`define MCRSU_STK_RELOAD_ADDR 12'h07f
`define MCRSU_STK_FLOOR 12'h061
`define MCRSU_FLG_C 0
`define MCRSU_FLG_Z 1
`define MCRSU_FLG_N 2
`define MCRSU_FLG_I 3
`define MCRSU_FLG_H 4
`define MCRSU_FLAGS_RST 5'h08
`define MCRSU_FLAGS_PAD 3'h7
`define MCRSU_IP_RST 12'h000
`define MCRSU_RESP_OKAY 2'h0
`define MCRSU_RESP_SLVERR 2'h2
`endif

/* mcrsu_pkg.sv */
// types shared by the register stack unit
package mcrsu_pkg;
	typedef enum logic [3:0] {
		CMD_NOP, CMD_ALU, CMD_JUMP, CMD_CALL, CMD_INTR, CMD_RTS, CMD_RTI,
		CMD_STACK_RELOAD, CMD_SET_MASK, CMD_CLR_MASK
	} mcrsu_cmd_t;
	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_CMP, ALU_AND, ALU_ORA, ALU_EOR,
		ALU_LDA, ALU_ASL, ALU_LSR, ALU_ROL, ALU_ROR, ALU_INC, ALU_DEC, ALU_BTB
	} mcrsu_alu_t;
	typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_PULL_ADDR, ST_PULL_DATA} mcrsu_state_t;
endpackage

/* mcrsu_alu.sv */
// arithmetic unit feeding the accumulator, index register and flags
module mcrsu_alu (
	input wire mcrsu_pkg::mcrsu_alu_t op, // operation
	input wire logic [7:0] a, // register operand
	input wire logic [7:0] b, // memory operand
	input wire logic cin, // carry in
	output logic [7:0] res, // result
	output logic h, // half carry
	output logic c, // carry or borrow out
	output logic upd_h, // half carry valid
	output logic upd_c, // carry valid
	output logic upd_nz, // n and z valid
	output logic wb // result written back
);
	logic [8:0] wide;
	logic [4:0] half;
	always_comb begin
		wide = 9'h000;
		half = 5'h00;
		res = b;
		h = 1'b0;
		c = 1'b0;
		upd_h = 1'b0;
		upd_c = 1'b0;
		upd_nz = 1'b1;
		wb = 1'b1;
		case (op)
			mcrsu_pkg::ALU_ADD, mcrsu_pkg::ALU_ADC: begin
				wide = {1'b0, a} + {1'b0, b} + {8'h00, cin & (op == mcrsu_pkg::ALU_ADC)};
				half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin & (op == mcrsu_pkg::ALU_ADC)};
				res = wide[7:0];
				h = half[4];
				c = wide[8];
				upd_h = 1'b1;
				upd_c = 1'b1;
			end
			mcrsu_pkg::ALU_SUB, mcrsu_pkg::ALU_SBC, mcrsu_pkg::ALU_CMP: begin
				wide = {1'b0, a} - {1'b0, b} - {8'h00, cin & (op == mcrsu_pkg::ALU_SBC)};
				res = wide[7:0];
				c = wide[8];
				upd_c = 1'b1;
				wb = (op != mcrsu_pkg::ALU_CMP);
			end
			mcrsu_pkg::ALU_AND: res = a & b;
			mcrsu_pkg::ALU_ORA: res = a | b;
			mcrsu_pkg::ALU_EOR: res = a ^ b;
			mcrsu_pkg::ALU_LDA: res = b;
			mcrsu_pkg::ALU_ASL: begin
				res = {a[6:0], 1'b0};
				c = a[7];
				upd_c = 1'b1;
			end
			mcrsu_pkg::ALU_LSR: begin
				res = {1'b0, a[7:1]};
				c = a[0];
				upd_c = 1'b1;
			end
			mcrsu_pkg::ALU_ROL: begin
				res = {a[6:0], cin};
				c = a[7];
				upd_c = 1'b1;
			end
			mcrsu_pkg::ALU_ROR: begin
				res = {cin, a[7:1]};
				c = a[0];
				upd_c = 1'b1;
			end
			mcrsu_pkg::ALU_INC: res = a + 8'h01;
			mcrsu_pkg::ALU_DEC: res = a - 8'h01;
			mcrsu_pkg::ALU_BTB: begin
				c = b[0];
				upd_c = 1'b1;
				upd_nz = 1'b0;
				wb = 1'b0;
			end
			default: wb = 1'b0;
		endcase
	end
endmodule

/* mcrsu_stack_ram.sv */
// stack window memory with registered read data
module mcrsu_stack_ram #(
	parameter int AW = 5, // address bits
	parameter int DW = 8 // data bits
) (
	input wire logic clk, // core clock
	input wire logic resetn, // sync reset, active low
	input wire logic we, // write strobe
	input wire logic [AW-1:0] waddr, // write address
	input wire logic [DW-1:0] wdata, // write data
	input wire logic [AW-1:0] raddr, // read address
	output logic [DW-1:0] rdata // read data, one cycle late
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

/* mcrsu_unit.sv */
// programmer-visible register set, stack sequencing and axi4-lite register access
// Contract
// - eight-bit accumulator holds operands and results of data operations
// - eight-bit index register, usable for read-modify-write and temporary storage
// - twelve-bit instruction pointer holds next instruction address
// - twelve-bit stack pointer always addresses the next free location
// - stack pointer decrements per byte pushed, increments per byte pulled
// - reset and the stack reload instruction force the stack pointer to 0x07f
// - upper stack pointer bits fixed at 0000011, only low bits count
// - nesting reaches 0x061 for fifteen calls, deeper nesting wraps in window
// - counter low byte pushed first, then high nibble
// - subroutine call pushes only the two instruction pointer bytes
// - five-bit flag register reflects last instruction, bits testable
// - add and add-with-carry set half carry from bit 3 into bit 4
// - masked interrupts stay pending, serviced once the mask clears
// - negative flag copies bit 7 of the last result
// - zero flag set when the last result is zero
// - carry records alu carry or borrow, bit test, shifts and rotates
// - interrupt entry sets the mask after stacking the state
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`include "mcrsu_regs.svh"
module mcrsu_unit #(
	parameter int ADDR_W = 8 // axi address width
) (
	input wire logic aclk, // core clock
	input wire logic aresetn, // sync reset, active low
	input wire logic cmd_valid, // sequencer command offered
	output logic cmd_ready, // command taken when both high
	input wire mcrsu_pkg::mcrsu_cmd_t cmd_op, // command
	input wire mcrsu_pkg::mcrsu_alu_t cmd_alu, // alu operation
	input wire logic cmd_to_idx, // alu targets index register
	input wire logic [7:0] cmd_data, // memory operand
	input wire logic [11:0] cmd_addr, // jump or call target
	input wire logic ext_irq_pin, // external interrupt pin
	input wire logic timer_irq, // timer interrupt pulse
	output logic irq_request, // unmasked interrupt pending
	output logic [1:0] irq_source, // source of last entry
	output logic [7:0] acc, // accumulator
	output logic [7:0] idx, // index register
	output logic [11:0] instruction_pointer, // next instruction address
	output logic [11:0] stack_top_pointer, // next free stack location
	output logic [7:0] flag_register, // flags with padding
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [ADDR_W-1:0] awaddr, // write address
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write strobes
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	output logic [1:0] bresp, // write response
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	input wire logic [ADDR_W-1:0] araddr, // read address
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp // read response
);
	mcrsu_pkg::mcrsu_state_t state;
	logic [4:0] flags;
	logic [4:0] stk_lo;
	logic [2:0] seq_idx;
	logic [2:0] seq_end;
	logic seq_intr;
	logic [11:0] tgt;
	logic [1:0] pend;
	logic ext_s1, ext_s2, ext_prev;
	logic cmd_fire, alu_fire, push_last, pull_dat, stk_reload;
	logic [7:0] push_byte, stk_rdata;
	logic [7:0] alu_a, alu_res;
	logic alu_h, alu_c, alu_upd_h, alu_upd_c, alu_upd_nz, alu_wb;
	logic aw_have, w_have, wr_go, bus_ok;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [1:0] pend_set, pend_clr;

	assign cmd_ready = (state == mcrsu_pkg::ST_IDLE);
	assign cmd_fire = cmd_valid & cmd_ready;
	assign alu_fire = cmd_fire & (cmd_op == mcrsu_pkg::CMD_ALU);
	assign push_last = (state == mcrsu_pkg::ST_PUSH) & (seq_idx == seq_end);
	assign pull_dat = (state == mcrsu_pkg::ST_PULL_DATA);
	assign stack_top_pointer = {`MCRSU_STK_FIXED, stk_lo};
	assign flag_register = {`MCRSU_FLAGS_PAD, flags};
	assign alu_a = cmd_to_idx ? idx : acc;

	mcrsu_alu u_alu (
		.op(cmd_alu),
		.a(alu_a),
		.b(cmd_data),
		.cin(flags[`MCRSU_FLG_C]),
		.res(alu_res),
		.h(alu_h),
		.c(alu_c),
		.upd_h(alu_upd_h),
		.upd_c(alu_upd_c),
		.upd_nz(alu_upd_nz),
		.wb(alu_wb)
	);

	// push order: low byte, high nibble, index, accumulator, flags
	always_comb begin
		case (seq_idx)
			3'd0: push_byte = instruction_pointer[7:0];
			3'd1: push_byte = {4'h0, instruction_pointer[11:8]};
			3'd2: push_byte = idx;
			3'd3: push_byte = acc;
			default: push_byte = flag_register;
		endcase
	end

	mcrsu_stack_ram #(.AW(5), .DW(8)) u_ram (
		.clk(aclk),
		.resetn(aresetn),
		.we(state == mcrsu_pkg::ST_PUSH),
		.waddr(stk_lo),
		.wdata(push_byte),
		.raddr(stk_lo + 5'h01),
		.rdata(stk_rdata)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= mcrsu_pkg::ST_IDLE;
			seq_idx <= 3'd0;
			seq_end <= 3'd0;
			seq_intr <= 1'b0;
			tgt <= `MCRSU_IP_RST;
		end else begin
			case (state)
				mcrsu_pkg::ST_IDLE: begin
					if (cmd_fire) begin
						tgt <= cmd_addr;
						case (cmd_op)
							mcrsu_pkg::CMD_CALL: begin
								state <= mcrsu_pkg::ST_PUSH;
								seq_idx <= 3'd0;
								seq_end <= 3'd1;
								seq_intr <= 1'b0;
							end
							mcrsu_pkg::CMD_INTR: begin
								state <= mcrsu_pkg::ST_PUSH;
								seq_idx <= 3'd0;
								seq_end <= 3'd4;
								seq_intr <= 1'b1;
							end
							mcrsu_pkg::CMD_RTS: begin
								state <= mcrsu_pkg::ST_PULL_ADDR;
								seq_idx <= 3'd1;
							end
							mcrsu_pkg::CMD_RTI: begin
								state <= mcrsu_pkg::ST_PULL_ADDR;
								seq_idx <= 3'd4;
							end
							default: state <= mcrsu_pkg::ST_IDLE;
						endcase
					end
				end
				mcrsu_pkg::ST_PUSH: begin
					if (push_last) begin
						state <= mcrsu_pkg::ST_IDLE;
					end else begin
						seq_idx <= seq_idx + 3'd1;
					end
				end
				mcrsu_pkg::ST_PULL_ADDR: state <= mcrsu_pkg::ST_PULL_DATA;
				mcrsu_pkg::ST_PULL_DATA: begin
					if (seq_idx == 3'd0) begin
						state <= mcrsu_pkg::ST_IDLE;
					end else begin
						seq_idx <= seq_idx - 3'd1;
						state <= mcrsu_pkg::ST_PULL_ADDR;
					end
				end
				default: state <= mcrsu_pkg::ST_IDLE;
			endcase
		end
	end

	// stack window wraps below the floor instead of leaving it
	assign stk_reload = (cmd_fire & (cmd_op == mcrsu_pkg::CMD_STACK_RELOAD))
		| (wr_go & (wr_addr == `MCRSU_OFS_CTRL) & wr_strb[0] & wr_data[`MCRSU_CTRL_RELOAD]);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stk_lo <= `MCRSU_STK_RELOAD;
		end else if (stk_reload) begin
			stk_lo <= `MCRSU_STK_RELOAD;
		end else if (state == mcrsu_pkg::ST_PUSH) begin
			stk_lo <= stk_lo - 5'h01;
		end else if (state == mcrsu_pkg::ST_PULL_ADDR) begin
			stk_lo <= stk_lo + 5'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc <= 8'h00;
		end else if (pull_dat && seq_idx == 3'd3) begin
			acc <= stk_rdata;
		end else if (alu_fire && alu_wb && !cmd_to_idx) begin
			acc <= alu_res;
		end else if (wr_go && wr_addr == `MCRSU_OFS_ACC && wr_strb[0]) begin
			acc <= wr_data[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idx <= 8'h00;
		end else if (pull_dat && seq_idx == 3'd2) begin
			idx <= stk_rdata;
		end else if (alu_fire && alu_wb && cmd_to_idx) begin
			idx <= alu_res;
		end else if (wr_go && wr_addr == `MCRSU_OFS_IDX && wr_strb[0]) begin
			idx <= wr_data[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instruction_pointer <= `MCRSU_IP_RST;
		end else if (pull_dat && seq_idx == 3'd1) begin
			instruction_pointer[11:8] <= stk_rdata[3:0];
		end else if (pull_dat && seq_idx == 3'd0) begin
			instruction_pointer[7:0] <= stk_rdata;
		end else if (push_last && !seq_intr) begin
			instruction_pointer <= tgt;
		end else if (cmd_fire && cmd_op == mcrsu_pkg::CMD_JUMP) begin
			instruction_pointer <= cmd_addr;
		end else if (wr_go && wr_addr == `MCRSU_OFS_IP) begin
			if (wr_strb[0]) begin
				instruction_pointer[7:0] <= wr_data[7:0];
			end
			if (wr_strb[1]) begin
				instruction_pointer[11:8] <= wr_data[11:8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= `MCRSU_FLAGS_RST;
		end else if (pull_dat && seq_idx == 3'd4) begin
			flags <= stk_rdata[4:0];
		end else if (push_last && seq_intr) begin
			flags[`MCRSU_FLG_I] <= 1'b1;
		end else if (alu_fire) begin
			if (alu_upd_h) begin
				flags[`MCRSU_FLG_H] <= alu_h;
			end
			if (alu_upd_nz) begin
				flags[`MCRSU_FLG_N] <= alu_res[7];
				flags[`MCRSU_FLG_Z] <= (alu_res == 8'h00);
			end
			if (alu_upd_c) begin
				flags[`MCRSU_FLG_C] <= alu_c;
			end
		end else if (cmd_fire && cmd_op == mcrsu_pkg::CMD_SET_MASK) begin
			flags[`MCRSU_FLG_I] <= 1'b1;
		end else if (cmd_fire && cmd_op == mcrsu_pkg::CMD_CLR_MASK) begin
			flags[`MCRSU_FLG_I] <= 1'b0;
		end else if (wr_go && wr_addr == `MCRSU_OFS_FLAGS && wr_strb[0]) begin
			flags <= wr_data[4:0];
		end
	end

	// pin synchroniser, edge taken from the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_s1 <= ext_irq_pin;
			ext_s2 <= ext_s1;
			ext_prev <= ext_s2;
		end
	end

	// external outranks timer; a new request beats its own clear
	assign pend_set = {timer_irq, ext_s2 & ~ext_prev};
	always_comb begin
		pend_clr = 2'b00;
		if (cmd_fire && cmd_op == mcrsu_pkg::CMD_INTR) begin
			pend_clr = pend[0] ? 2'b01 : {pend[1], 1'b0};
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend <= 2'b00;
			irq_source <= 2'b00;
		end else begin
			pend <= (pend & ~pend_clr) | pend_set;
			if (cmd_fire && cmd_op == mcrsu_pkg::CMD_INTR) begin
				irq_source <= pend_clr;
			end
		end
	end
	assign irq_request = (|pend) & ~flags[`MCRSU_FLG_I];

	// axi4-lite write: address and data in either order
	assign bus_ok = (state == mcrsu_pkg::ST_IDLE) & ~cmd_fire;
	assign awready = ~aw_have;
	assign wready = ~w_have;
	assign wr_go = aw_have & w_have & ~bvalid & bus_ok;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			wr_addr <= '0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `MCRSU_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_have <= 1'b1;
				wr_addr <= awaddr;
			end else if (wr_go) begin
				aw_have <= 1'b0;
			end
			if (wvalid && wready) begin
				w_have <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end else if (wr_go) begin
				w_have <= 1'b0;
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				case (wr_addr)
					`MCRSU_OFS_ACC, `MCRSU_OFS_IDX, `MCRSU_OFS_IP, `MCRSU_OFS_FLAGS, `MCRSU_OFS_CTRL:
						bresp <= `MCRSU_RESP_OKAY;
					default: bresp <= `MCRSU_RESP_SLVERR;
				endcase
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	assign arready = ~rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `MCRSU_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= `MCRSU_RESP_OKAY;
			case (araddr)
				`MCRSU_OFS_ACC: rdata <= {24'h00_0000, acc};
				`MCRSU_OFS_IDX: rdata <= {24'h00_0000, idx};
				`MCRSU_OFS_IP: rdata <= {20'h0_0000, instruction_pointer};
				`MCRSU_OFS_STK: rdata <= {20'h0_0000, stack_top_pointer};
				`MCRSU_OFS_FLAGS: rdata <= {24'h00_0000, flag_register};
				`MCRSU_OFS_STATUS: rdata <= {29'h0000_0000, pend, state != mcrsu_pkg::ST_IDLE};
				`MCRSU_OFS_CTRL: rdata <= 32'h0000_0000;
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= `MCRSU_RESP_SLVERR;
				end
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	logic [4:0] h_sum;
	assign h_sum = {1'b0, alu_a[3:0]} + {1'b0, cmd_data[3:0]};
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_stack_fixed_bits: assert property (
		stack_top_pointer[11:5] == `MCRSU_STK_FIXED) else $error("stack pointer upper bits changed");
	a_stack_reload: assert property (
		cmd_fire && cmd_op == mcrsu_pkg::CMD_STACK_RELOAD |=> stack_top_pointer == `MCRSU_STK_RELOAD_ADDR)
		else $error("stack reload missed 0x07f");
	a_push_decrement: assert property (
		state == mcrsu_pkg::ST_PUSH && !stk_reload |=> stk_lo == 5'($past(stk_lo) - 5'h01))
		else $error("push did not decrement stack pointer");
	a_pull_increment: assert property (
		state == mcrsu_pkg::ST_PULL_ADDR |=> stk_lo == 5'($past(stk_lo) + 5'h01))
		else $error("pull did not increment stack pointer");
	a_call_two_bytes: assert property (
		cmd_fire && cmd_op == mcrsu_pkg::CMD_CALL |=> state == mcrsu_pkg::ST_PUSH [*2] ##1 state == mcrsu_pkg::ST_IDLE)
		else $error("call pushed other than two bytes");
	a_low_byte_first: assert property (
		state == mcrsu_pkg::ST_PUSH && seq_idx == 3'd0 |-> push_byte == instruction_pointer[7:0]
		##1 push_byte == {4'h0, instruction_pointer[11:8]}) else $error("stacking order wrong");
	a_intr_sets_mask: assert property (
		cmd_fire && cmd_op == mcrsu_pkg::CMD_INTR |-> ##5 push_byte[`MCRSU_FLG_I] == $past(flags[`MCRSU_FLG_I], 5)
		##1 flags[`MCRSU_FLG_I]) else $error("mask not set after interrupt stacking");
	a_pending_held: assert property (
		pend[0] && !(cmd_fire && cmd_op == mcrsu_pkg::CMD_INTR) |=> pend[0]) else $error("pending request lost");
	a_half_carry: assert property (
		alu_fire && cmd_alu == mcrsu_pkg::ALU_ADD |=> flags[`MCRSU_FLG_H] == $past(h_sum[4]))
		else $error("half carry wrong");
	a_zero_negative: assert property (
		alu_fire && cmd_alu == mcrsu_pkg::ALU_LDA |=> flags[`MCRSU_FLG_Z] == ($past(cmd_data) == 8'h00)
		&& flags[`MCRSU_FLG_N] == $past(cmd_data[7])) else $error("zero or negative flag wrong");
	a_flags_pad: assert property (
		flag_register[7:5] == `MCRSU_FLAGS_PAD) else $error("flag padding not ones");

	c_call: cover property (cmd_fire && cmd_op == mcrsu_pkg::CMD_CALL);
	c_intr: cover property (cmd_fire && cmd_op == mcrsu_pkg::CMD_INTR ##6 state == mcrsu_pkg::ST_IDLE);
	c_rti: cover property (pull_dat && seq_idx == 3'd0);
	c_masked_then_served: cover property (|pend && flags[`MCRSU_FLG_I] ##[1:20] irq_request);
endmodule

/* tb_mcu_cpu_register_stack_unit.sv */
// self-checking bench for the register stack unit
`define CHK(g, e) \
	begin \
		tests_run++; \
		if ((g) !== (e)) begin \
			num_errors++; \
			$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
		end \
	end
module tb_mcu_cpu_register_stack_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, cmd_valid = 0, cmd_to_idx = 0, ext_irq_pin = 0, timer_irq = 0;
	mcrsu_pkg::mcrsu_cmd_t cmd_op = mcrsu_pkg::CMD_NOP;
	mcrsu_pkg::mcrsu_alu_t cmd_alu = mcrsu_pkg::ALU_ADD;
	logic [7:0] cmd_data = 8'h00, awaddr = 8'h00, araddr = 8'h00, acc, idx, flag_register;
	logic [11:0] cmd_addr = 12'h000, instruction_pointer, stack_top_pointer;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 32'h0000_0000, rdata, rd;
	logic [3:0] wstrb = 4'h0;
	logic cmd_ready, irq_request, awready, wready, bvalid, arready, rvalid;
	logic [1:0] irq_source, bresp, rresp, rs;
	int num_errors = 0, tests_run = 0;

	mcrsu_unit mcrsu_unit_inst (.aclk, .aresetn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_alu, .cmd_to_idx, .cmd_data,
		.cmd_addr, .ext_irq_pin, .timer_irq, .irq_request, .irq_source, .acc, .idx, .instruction_pointer,
		.stack_top_pointer, .flag_register, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

	initial begin
		forever #4 aclk = ~aclk;
	end

	task automatic cmd(input mcrsu_pkg::mcrsu_cmd_t op, input logic [11:0] a = 12'h000,
		input mcrsu_pkg::mcrsu_alu_t f = mcrsu_pkg::ALU_LDA, input logic ti = 0, input logic [7:0] d = 8'h00);
		@(posedge aclk);
		cmd_valid <= 1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_alu <= f;
		cmd_to_idx <= ti;
		cmd_data <= d;
		// command stands until an edge samples ready high
		do begin
			@(posedge aclk);
		end while (cmd_ready !== 1'b1);
		cmd_valid <= 0;
		// settled outputs are judged at the falling edge
		do begin
			@(negedge aclk);
		end while (cmd_ready !== 1'b1);
	endtask

	task automatic alu(input mcrsu_pkg::mcrsu_alu_t f, input logic [7:0] d, input logic ti = 0);
		cmd(mcrsu_pkg::CMD_ALU, 12'h000, f, ti, d);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		logic aw, w;
		aw = 1;
		w = 1;
		@(posedge aclk);
		awvalid <= 1;
		wvalid <= 1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (aw && awready === 1'b1) begin
				aw = 0;
				awvalid <= 0;
			end
			if (w && wready === 1'b1) begin
				w = 0;
				wvalid <= 0;
			end
		end while (aw || w || bvalid !== 1'b1);
		rs = bresp;
		bready <= 0;
	endtask

	task automatic rdr(input logic [7:0] a);
		logic ar;
		ar = 1;
		@(posedge aclk);
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (ar && arready === 1'b1) begin
				ar = 0;
				arvalid <= 0;
			end
		end while (ar || rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 0;
	endtask

	task t_reset;
		`CHK(acc, 8'h00)
		`CHK(idx, 8'h00)
		`CHK(instruction_pointer, 12'h000)
		`CHK(stack_top_pointer, 12'h07f)
		`CHK(flag_register, 8'he8)
		rdr(8'h10);
		`CHK(rd, 32'h0000_00e8)
		rdr(8'h0c);
		`CHK(rd, 32'h0000_007f)
		$display("reset values done");
	endtask

	task t_alu;
		alu(mcrsu_pkg::ALU_LDA, 8'h80);
		`CHK(flag_register[2:1], 2'h2)
		alu(mcrsu_pkg::ALU_ADD, 8'h80);
		`CHK(acc, 8'h00)
		`CHK(flag_register, 8'heb)
		alu(mcrsu_pkg::ALU_LDA, 8'h0f);
		alu(mcrsu_pkg::ALU_ADD, 8'h01);
		`CHK(flag_register, 8'hf8)
		alu(mcrsu_pkg::ALU_LDA, 8'h00);
		alu(mcrsu_pkg::ALU_SUB, 8'h01);
		`CHK(acc, 8'hff)
		`CHK(flag_register[2:0], 3'h5)
		alu(mcrsu_pkg::ALU_ADC, 8'h00);
		`CHK(flag_register, 8'hfb)
		alu(mcrsu_pkg::ALU_BTB, 8'h00);
		`CHK(flag_register[0], 1'h0)
		alu(mcrsu_pkg::ALU_LDA, 8'h5a, 1);
		alu(mcrsu_pkg::ALU_ADD, 8'h01, 1);
		`CHK(idx, 8'h5b)
		`CHK(acc, 8'h00)
		alu(mcrsu_pkg::ALU_LDA, 8'h81);
		alu(mcrsu_pkg::ALU_ASL, 8'h00);
		`CHK(acc, 8'h02)
		`CHK(flag_register[0], 1'h1)
		alu(mcrsu_pkg::ALU_ROR, 8'h00);
		`CHK(acc, 8'h81)
		`CHK(flag_register[0], 1'h0)
		alu(mcrsu_pkg::ALU_CMP, 8'h81);
		`CHK(acc, 8'h81)
		`CHK(flag_register[2:0], 3'h2)
		alu(mcrsu_pkg::ALU_ROL, 8'h00);
		`CHK(acc, 8'h02)
		`CHK(flag_register[0], 1'h1)
		$display("flag updates done");
	endtask

	task t_call;
		cmd(mcrsu_pkg::CMD_JUMP, 12'h123);
		cmd(mcrsu_pkg::CMD_CALL, 12'h456);
		`CHK(instruction_pointer, 12'h456)
		`CHK(stack_top_pointer, 12'h07d)
		cmd(mcrsu_pkg::CMD_RTS);
		`CHK(instruction_pointer, 12'h123)
		`CHK(stack_top_pointer, 12'h07f)
		for (int i = 0; i < 15; i++) begin
			cmd(mcrsu_pkg::CMD_CALL, 12'(i));
		end
		`CHK(stack_top_pointer, 12'h061)
		cmd(mcrsu_pkg::CMD_CALL);
		`CHK(stack_top_pointer, 12'h07f)
		cmd(mcrsu_pkg::CMD_CALL);
		cmd(mcrsu_pkg::CMD_STACK_RELOAD);
		`CHK(stack_top_pointer, 12'h07f)
		cmd(mcrsu_pkg::CMD_CALL);
		wr(8'h18, 32'h0000_0001);
		`CHK(stack_top_pointer, 12'h07f)
		$display("call nesting done");
	endtask

	task t_intr;
		cmd(mcrsu_pkg::CMD_JUMP, 12'h2a5);
		wr(8'h10, 32'h0000_0015);
		wr(8'h00, 32'h0000_003c);
		wr(8'h04, 32'h0000_00c3);
		cmd(mcrsu_pkg::CMD_INTR);
		`CHK(stack_top_pointer, 12'h07a)
		`CHK(flag_register, 8'hfd)
		alu(mcrsu_pkg::ALU_LDA, 8'h00);
		alu(mcrsu_pkg::ALU_LDA, 8'h00, 1);
		cmd(mcrsu_pkg::CMD_JUMP, 12'h000);
		cmd(mcrsu_pkg::CMD_RTI);
		`CHK(acc, 8'h3c)
		`CHK(idx, 8'hc3)
		`CHK(flag_register, 8'hf5)
		`CHK(instruction_pointer, 12'h2a5)
		`CHK(stack_top_pointer, 12'h07f)
		$display("interrupt entry and return done");
	endtask

	task t_mask;
		cmd(mcrsu_pkg::CMD_SET_MASK);
		@(posedge aclk);
		timer_irq <= 1;
		@(posedge aclk);
		timer_irq <= 0;
		ext_irq_pin <= 1;
		repeat (5) @(posedge aclk);
		`CHK(irq_request, 1'h0)
		rdr(8'h14);
		`CHK(rd, 32'h0000_0006)
		cmd(mcrsu_pkg::CMD_CLR_MASK);
		`CHK(irq_request, 1'h1)
		cmd(mcrsu_pkg::CMD_INTR);
		`CHK(irq_source, 2'h1)
		`CHK(irq_request, 1'h0)
		@(posedge aclk);
		ext_irq_pin <= 0;
		cmd(mcrsu_pkg::CMD_RTI);
		`CHK(irq_request, 1'h1)
		cmd(mcrsu_pkg::CMD_INTR);
		`CHK(irq_source, 2'h2)
		cmd(mcrsu_pkg::CMD_STACK_RELOAD);
		$display("masked requests done");
	endtask

	task t_bus;
		wr(8'h10, 32'h0000_00ff);
		`CHK(flag_register, 8'hff)
		wr(8'h10, 32'h0000_0000);
		rdr(8'h10);
		`CHK(rd, 32'h0000_00e0)
		wr(8'h0c, 32'h0000_0001);
		`CHK(rs, 2'h2)
		`CHK(stack_top_pointer, 12'h07f)
		rdr(8'h1c);
		`CHK(rs, 2'h2)
		wr(8'h08, 32'h0000_0abc, 4'h3);
		`CHK(instruction_pointer, 12'habc)
		wr(8'h00, 32'h1234_5678);
		rdr(8'h00);
		`CHK(rd, 32'h0000_0078)
		$display("register access done");
	endtask

	task complete_run;
		$display("mismatches %0d of %0d comparisons", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		@(negedge aclk);
		t_reset;
		t_alu;
		t_call;
		t_intr;
		t_mask;
		t_bus;
		complete_run;
	end

	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge aclk);
		num_errors++;
		complete_run;
	end
endmodule
